// >>> rtl/ptcb_bank.v
// pack topology configuration bank with an apb3 slave port
// assumes: single clock pclk, async active-low presetn, apb master on pclk
`timescale 1ns/1ps
`include "ptcb_regs.vh"

// Function
// [R1] each cell selector is a two-bit code and the chosen sensor is the code plus one, one to four.
// [R2] four cell selectors per byte in ascending bit pairs, cell 4 on top of byte 0, cells 5-8 in byte 1.
// [R3] cells nine to twelve sit in the third selector byte, low pair first.
// [R4] cells thirteen to sixteen sit in the fourth selector byte, cell 13 lowest.
// [R5] after reset every cell selector picks sensor one.
// [R6] the series cell count is a five-bit low field, valid from two to sixteen.
// [R7] after reset the series cell count reads sixteen.
// [R8] the parallel cell count is a full byte, valid from one to 255.
// [R9] after reset the parallel cell count reads one.
// [R10] a three-bit sensor count, one to four, bounds the sensors a cell may select.
// [R11] a selector byte write updates its four cells at once and a read returns all four.
module ptcb_bank #(
   parameter ADDR_W = `PTCB_ADDR_W
) (
   input  wire                                         pclk,              // apb clock
   input  wire                                         presetn,           // async reset, low
   input  wire [ADDR_W-1:0]                            paddr,             // byte address
   input  wire                                         psel,              // slave select
   input  wire                                         penable,           // access phase
   input  wire                                         pwrite,            // 1 write, 0 read
   input  wire [31:0]                                  pwdata,            // write data
   output reg  [31:0]                                  prdata,            // read data
   output reg                                          pready,            // transfer done
   output reg                                          pslverr,           // transfer error
   output reg  [`PTCB_CELLS*`PTCB_SENSOR_NUM_W-1:0]    cell_sensor_num,   // sensor per cell
   output reg  [`PTCB_CELLS-1:0]                       cell_sensor_bad,   // beyond sensor count
   output reg  [`PTCB_SER_MSB:0]                       series_cell_count, // series cells
   output reg  [`PTCB_PAR_MSB:0]                       parallel_cell_count, // parallel cells
   output reg  [`PTCB_NSENS_MSB:0]                     pack_sensor_count  // sensors in pack
);

   // ****************************************************************
   // storage
   // ****************************************************************
   reg  [31:0]                 sel_reg;        // four selector bytes, group0 low
   reg  [`PTCB_SER_MSB:0]      series_reg;
   reg  [`PTCB_PAR_MSB:0]      parallel_reg;
   reg  [`PTCB_NSENS_MSB:0]    sensors_reg;
   reg                         wr_pend_reg;    // setup decided an accepted write
   reg  [2:0]                  wr_target_reg;  // which register it hits
   reg  [31:0]                 prdata_next;
   reg                         pslverr_next;
   reg                         wr_ok_next;
   reg  [2:0]                  wr_target_next;

   localparam [2:0] TGT_G0  = 3'h0;
   localparam [2:0] TGT_G1  = 3'h1;
   localparam [2:0] TGT_G2  = 3'h2;
   localparam [2:0] TGT_G3  = 3'h3;
   localparam [2:0] TGT_SER = 3'h4;
   localparam [2:0] TGT_PAR = 3'h5;
   localparam [2:0] TGT_NS  = 3'h6;
   localparam [2:0] TGT_NONE = 3'h7;

   wire        setup  = psel & ~penable;
   wire        access = psel & penable & pready;
   wire [7:0]  wbyte  = pwdata[7:0];
   wire [`PTCB_ADDR_W-1:0] addr16 = paddr[`PTCB_ADDR_W-1:0];

   // ****************************************************************
   // range checks on the written byte
   // ****************************************************************
   wire        ser_in_range = (wbyte >= `PTCB_SER_MIN) && (wbyte <= `PTCB_SER_MAX);     // [R6]
   wire        par_in_range = (wbyte >= `PTCB_PAR_MIN);                               // [R8]
   wire        ns_in_range  = (wbyte >= `PTCB_NSENS_MIN) && (wbyte <= `PTCB_NSENS_MAX); // [R10]

   // ****************************************************************
   // decode at setup: read data, error and write legality
   // ****************************************************************
   always @* begin
      prdata_next    = 32'h0000_0000;
      pslverr_next   = 1'b0;
      wr_ok_next     = 1'b0;
      wr_target_next = TGT_NONE;
      case (addr16)
         `PTCB_ADDR_GROUP0: begin
            prdata_next    = {24'h00_0000, sel_reg[7:0]};     // [R11]
            wr_target_next = TGT_G0;
            wr_ok_next     = 1'b1;
         end
         `PTCB_ADDR_GROUP1: begin
            prdata_next    = {24'h00_0000, sel_reg[15:8]};    // [R11]
            wr_target_next = TGT_G1;
            wr_ok_next     = 1'b1;
         end
         `PTCB_ADDR_GROUP2: begin
            prdata_next    = {24'h00_0000, sel_reg[23:16]};   // [R3]
            wr_target_next = TGT_G2;
            wr_ok_next     = 1'b1;
         end
         `PTCB_ADDR_GROUP3: begin
            prdata_next    = {24'h00_0000, sel_reg[31:24]};   // [R4]
            wr_target_next = TGT_G3;
            wr_ok_next     = 1'b1;
         end
         `PTCB_ADDR_SERIES: begin
            prdata_next    = {27'h0, series_reg};             // [R6]
            wr_target_next = TGT_SER;
            // out of range count is refused, register unchanged
            wr_ok_next     = ser_in_range;                    // [R6]
         end
         `PTCB_ADDR_PARALLEL: begin
            prdata_next    = {24'h00_0000, parallel_reg};     // [R8]
            wr_target_next = TGT_PAR;
            wr_ok_next     = par_in_range;                    // [R8]
         end
         `PTCB_ADDR_SENSORS: begin
            prdata_next    = {29'h0, sensors_reg};            // [R10]
            wr_target_next = TGT_NS;
            wr_ok_next     = ns_in_range;                     // [R10]
         end
         `PTCB_ADDR_STATUS: begin
            prdata_next    = {16'h0000, cell_sensor_bad};
            wr_target_next = TGT_NONE;
            wr_ok_next     = 1'b0;
         end
         default: begin
            prdata_next    = 32'h0000_0000;
            pslverr_next   = 1'b1;
            wr_ok_next     = 1'b0;
         end
      endcase
      if (pwrite) begin
         prdata_next = 32'h0000_0000;
         if (!wr_ok_next) begin
            pslverr_next = 1'b1;
         end
      end
   end

   // ****************************************************************
   // apb handshake: one setup, one access cycle, no wait states
   // ****************************************************************
   // pready stands for exactly the access cycle after each setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // read data and error latched at setup, cleared after the access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= prdata_next;
         pslverr <= pslverr_next;
      end else if (access) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // write decision taken at setup, applied at the access edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_pend_reg   <= 1'b0;
         wr_target_reg <= TGT_NONE;
      end else if (setup) begin
         wr_pend_reg   <= pwrite & wr_ok_next;
         wr_target_reg <= wr_target_next;
      end else if (access) begin
         wr_pend_reg   <= 1'b0;
         wr_target_reg <= TGT_NONE;
      end
   end

   // ****************************************************************
   // write strobes, one per register, only at an accepted access
   // ****************************************************************
   wire        commit = access & wr_pend_reg;
   wire        wr_g0  = commit & (wr_target_reg == TGT_G0);
   wire        wr_g1  = commit & (wr_target_reg == TGT_G1);
   wire        wr_g2  = commit & (wr_target_reg == TGT_G2);
   wire        wr_g3  = commit & (wr_target_reg == TGT_G3);
   wire        wr_ser = commit & (wr_target_reg == TGT_SER);
   wire        wr_par = commit & (wr_target_reg == TGT_PAR);
   wire        wr_ns  = commit & (wr_target_reg == TGT_NS);

   // ****************************************************************
   // selector bytes: a write replaces all four pairs of one byte
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_reg <= {4{`PTCB_RST_GROUP}};                   // [R5]
      end else begin
         // cells 1 to 4
         if (wr_g0) begin
            sel_reg[7:0] <= wbyte;                          // [R2] [R11]
         end
         // cells 5 to 8
         if (wr_g1) begin
            sel_reg[15:8] <= wbyte;                         // [R2] [R11]
         end
         // cells 9 to 12
         if (wr_g2) begin
            sel_reg[23:16] <= wbyte;                        // [R3] [R11]
         end
         // cells 13 to 16
         if (wr_g3) begin
            sel_reg[31:24] <= wbyte;                        // [R4] [R11]
         end
      end
   end

   // ****************************************************************
   // series count: a refused write never raises its strobe
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         series_reg <= `PTCB_RST_SERIES;                    // [R7]
      end else if (wr_ser) begin
         series_reg <= wbyte[`PTCB_SER_MSB:0];              // [R6]
      end
   end

   // ****************************************************************
   // parallel count
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parallel_reg <= `PTCB_RST_PARALLEL;                // [R9]
      end else if (wr_par) begin
         parallel_reg <= wbyte[`PTCB_PAR_MSB:0];            // [R8]
      end
   end

   // ****************************************************************
   // sensor count
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sensors_reg <= `PTCB_RST_SENSORS;
      end else if (wr_ns) begin
         sensors_reg <= wbyte[`PTCB_NSENS_MSB:0];           // [R10]
      end
   end

   // ****************************************************************
   // per-cell decode: one small decoder per cell
   // ****************************************************************
   wire [`PTCB_CELLS*`PTCB_SENSOR_NUM_W-1:0] cell_num_w;   // decoded sensor numbers
   wire [`PTCB_CELLS-1:0]                    cell_bad_w;   // beyond sensor count

   genvar c;
   generate
      for (c = 0; c < `PTCB_CELLS; c = c + 1) begin : g_cell
         // cell c+1 takes pair c: four pairs a byte, ascending
         ptcb_cell_decode #(
            .SEL_W   (`PTCB_SEL_W),
            .NUM_W   (`PTCB_SENSOR_NUM_W)
         ) u_dec (
            .code    (sel_reg[`PTCB_SEL_W*c +: `PTCB_SEL_W]),                 // [R2]
            .sensors (sensors_reg),                                             // [R10]
            .num     (cell_num_w[`PTCB_SENSOR_NUM_W*c +: `PTCB_SENSOR_NUM_W]),  // [R1]
            .bad     (cell_bad_w[c])                                            // [R10]
         );
      end
   endgenerate

   // ****************************************************************
   // decoded cell outputs, one clock behind the selector bytes
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cell_sensor_num <= {`PTCB_CELLS{`PTCB_SEL_OFFSET}};   // [R5]
      end else begin
         cell_sensor_num <= cell_num_w;                        // [R1]
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cell_sensor_bad <= {`PTCB_CELLS{1'b0}};
      end else begin
         cell_sensor_bad <= cell_bad_w;                        // [R10]
      end
   end

   // ****************************************************************
   // series count output
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         series_cell_count <= `PTCB_RST_SERIES;             // [R7]
      end else begin
         series_cell_count <= series_reg;                   // [R6]
      end
   end

   // ****************************************************************
   // parallel count output
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parallel_cell_count <= `PTCB_RST_PARALLEL;         // [R9]
      end else begin
         parallel_cell_count <= parallel_reg;               // [R8]
      end
   end

   // ****************************************************************
   // sensor count output
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pack_sensor_count <= `PTCB_RST_SENSORS;
      end else begin
         pack_sensor_count <= sensors_reg;                  // [R10]
      end
   end

endmodule // ptcb_bank

// ****************************************************************
// cell decoder: stored code plus offset, flagged past sensor count
// ****************************************************************
module ptcb_cell_decode #(
   parameter SEL_W = `PTCB_SEL_W,
   parameter NUM_W = `PTCB_SENSOR_NUM_W
) (
   input  wire [SEL_W-1:0] code,     // stored selector pair
   input  wire [NUM_W-1:0] sensors,  // sensors fitted in pack
   output wire [NUM_W-1:0] num,      // selected sensor number
   output wire             bad       // selects a missing sensor
);

   // ****************************************************************
   // decode
   // ****************************************************************
   wire [NUM_W-1:0] code_ext = {{(NUM_W-SEL_W){1'b0}}, code};

   // offset makes code zero the first sensor
   assign num = code_ext + `PTCB_SEL_OFFSET;                   // [R1]
   assign bad = (num > sensors);                               // [R10]

endmodule // ptcb_cell_decode

// >>> rtl/ptcb_regs.vh
// register map and constants of the pack topology configuration bank
// assumes: included by the bank module, apb byte address = 4 x index
`ifndef PTCB_REGS_VH
`define PTCB_REGS_VH

// ****************************************************************
// register indices and byte addresses
// ****************************************************************
`define PTCB_IDX_GROUP0        16'h1200
`define PTCB_IDX_GROUP1        16'h1201
`define PTCB_IDX_GROUP2        16'h1202
`define PTCB_IDX_GROUP3        16'h1203
`define PTCB_IDX_SERIES        16'h1204
`define PTCB_IDX_PARALLEL      16'h1205
`define PTCB_IDX_SENSORS       16'h1206
`define PTCB_IDX_STATUS        16'h1280
`define PTCB_ADDR_W            16
`define PTCB_BYTE_ADDR(i)      ((i) << 2)
`define PTCB_ADDR_GROUP0       `PTCB_BYTE_ADDR(`PTCB_IDX_GROUP0)
`define PTCB_ADDR_GROUP1       `PTCB_BYTE_ADDR(`PTCB_IDX_GROUP1)
`define PTCB_ADDR_GROUP2       `PTCB_BYTE_ADDR(`PTCB_IDX_GROUP2)
`define PTCB_ADDR_GROUP3       `PTCB_BYTE_ADDR(`PTCB_IDX_GROUP3)
`define PTCB_ADDR_SERIES       `PTCB_BYTE_ADDR(`PTCB_IDX_SERIES)
`define PTCB_ADDR_PARALLEL     `PTCB_BYTE_ADDR(`PTCB_IDX_PARALLEL)
`define PTCB_ADDR_SENSORS      `PTCB_BYTE_ADDR(`PTCB_IDX_SENSORS)
`define PTCB_ADDR_STATUS       `PTCB_BYTE_ADDR(`PTCB_IDX_STATUS)

// ****************************************************************
// field layout
// ****************************************************************
`define PTCB_SEL_W             2
`define PTCB_SENSOR_NUM_W      3
`define PTCB_CELLS             16
`define PTCB_SER_MSB           4
`define PTCB_PAR_MSB           7
`define PTCB_NSENS_MSB         2

// ****************************************************************
// reset values and valid ranges
// ****************************************************************
`define PTCB_RST_GROUP         8'h00
`define PTCB_RST_SERIES        5'h10
`define PTCB_RST_PARALLEL      8'h01
`define PTCB_RST_SENSORS       3'h1
`define PTCB_SER_MIN           8'h02
`define PTCB_SER_MAX           8'h10
`define PTCB_PAR_MIN           8'h01
`define PTCB_NSENS_MIN         8'h01
`define PTCB_NSENS_MAX         8'h04
`define PTCB_SEL_OFFSET        3'h1

`endif

// >>> bench/ptcb_bank_assertions.sv
// port checker of the pack topology configuration bank
// assumes: bound into ptcb_bank, zero wait state apb slave
`timescale 1ns/1ps
module ptcb_bank_checker #(
   parameter ADDR_W = 16
) (
   input wire              pclk,                // clock
   input wire              presetn,             // reset, low
   input wire [ADDR_W-1:0] paddr,               // address
   input wire              psel,                // select
   input wire              penable,             // access
   input wire              pwrite,              // direction
   input wire [31:0]       pwdata,              // write data
   input wire              pready,              // done
   input wire              pslverr,             // error
   input wire [47:0]       cell_sensor_num,     // sensor per cell
   input wire [4:0]        series_cell_count,   // series
   input wire [7:0]        parallel_cell_count, // parallel
   input wire [2:0]        pack_sensor_count    // sensors
);
   // ****************************************
   // sequences and properties
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   function automatic [11:0] dec(input [7:0] b);
      dec = {{1'b0, b[7:6]} + 3'h1, {1'b0, b[5:4]} + 3'h1,
             {1'b0, b[3:2]} + 3'h1, {1'b0, b[1:0]} + 3'h1};
   endfunction
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_wr(logic [15:0] a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence
   property p_grp(logic [15:0] a, logic [11:0] sl);
      s_wr(a) ##0 !pslverr |-> ##2 sl == dec($past(pwdata[7:0], 2));
   endproperty
   a_ready_one_cycle: assert property (s_setup |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
   a_sel_reset: assert property ($rose(presetn) |-> cell_sensor_num == {16{3'h1}})
      else $error("selectors not sensor one after reset");
   a_count_reset: assert property ($rose(presetn) |-> series_cell_count == 5'h10 &&
      parallel_cell_count == 8'h01 && pack_sensor_count == 3'h1)
      else $error("counts wrong after reset");
   a_group0_decode: assert property (p_grp(16'h4800, cell_sensor_num[11:0]))
      else $error("group0 decode wrong");
   a_group2_decode: assert property (p_grp(16'h4808, cell_sensor_num[35:24]))
      else $error("group2 decode wrong");
   a_group3_decode: assert property (p_grp(16'h480c, cell_sensor_num[47:36]))
      else $error("group3 decode wrong");
   a_series_take: assert property (s_wr(16'h4810) ##0 !pslverr |-> ##2
      series_cell_count == $past(pwdata[4:0], 2))
      else $error("series count not taken");
   a_series_refuse: assert property (s_wr(16'h4810) ##0
      (pwdata[7:0] < 8'h02 || pwdata[7:0] > 8'h10) |->
      pslverr ##2 series_cell_count == $past(series_cell_count, 2))
      else $error("bad series count not refused");
endmodule // ptcb_bank_checker

bind ptcb_bank ptcb_bank_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .cell_sensor_num(cell_sensor_num),
   .series_cell_count(series_cell_count), .parallel_cell_count(parallel_cell_count),
   .pack_sensor_count(pack_sensor_count));

// >>> bench/ptcb_testbench.sv
// self-checking bench of the pack topology configuration bank
// assumes: design and checker compiled first, apb slave on a 20 MHz clock
`timescale 1ns/1ps
module testbench;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [15:0] paddr = 16'h0000;
   reg  [31:0] pwdata = 32'h0;
   reg  [31:0] rd;
   reg         er;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire [47:0] sel_num;
   wire [4:0]  ser;
   wire [7:0]  par;
   wire [2:0]  nsens;
   wire [15:0] bad;
   integer     err_total = 0;
   integer     cmp_count = 0;
   integer     cyc = 0;
   integer     g;
   reg  [7:0]  pats [0:3];
   ptcb_bank DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cell_sensor_num(sel_num),
      .cell_sensor_bad(bad), .series_cell_count(ser),
      .parallel_cell_count(par), .pack_sensor_count(nsens));
   // ****************************************
   // tasks
   // ****************************************
   function [11:0] dec(input [7:0] b);
      dec = {{1'b0, b[7:6]} + 3'h1, {1'b0, b[5:4]} + 3'h1,
             {1'b0, b[3:2]} + 3'h1, {1'b0, b[1:0]} + 3'h1};
   endfunction
   task close_out;
      if (err_total == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input [47:0] got, input [47:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task apb(input [15:0] a, input w, input [7:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         paddr <= a;
         pwrite <= w;
         pwdata <= {24'h0, d};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wchk(input [15:0] a, input [7:0] d, input e);
      begin
         apb(a, 1'b1, d);
         chk({47'h0, er}, {47'h0, e});
      end
   endtask
   task rchk(input [15:0] a, input [31:0] e);
      begin
         apb(a, 1'b0, 8'h00);
         chk({16'h0, rd}, {16'h0, e});
      end
   endtask
   task rst_chk;
      begin
         for (g = 0; g < 4; g = g + 1) rchk({12'h480, g[1:0], 2'b00}, 32'h0);
         rchk(16'h4810, 32'h10);
         rchk(16'h4814, 32'h01);
         rchk(16'h4818, 32'h01);
         chk(sel_num, {16{3'h1}});
         chk({32'h0, ser, par, nsens}, {32'h0, 5'h10, 8'h01, 3'h1});
      end
   endtask
   // ****************************************
   // clock, timeout and main sequence
   // ****************************************
   initial forever #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc > 5000) begin
         err_total = err_total + 1;
         close_out;
      end
   end
   initial begin
      pats[0] = 8'he4;
      pats[1] = 8'h1b;
      pats[2] = 8'h39;
      pats[3] = 8'hc6;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rst_chk;
      for (g = 0; g < 4; g = g + 1) begin
         wchk({12'h480, g[1:0], 2'b00}, pats[g], 1'b0);
         rchk({12'h480, g[1:0], 2'b00}, {24'h0, pats[g]});
         chk({36'h0, sel_num[g*12 +: 12]}, {36'h0, dec(pats[g])});
      end
      wchk(16'h4810, 8'h02, 1'b0);
      wchk(16'h4810, 8'h01, 1'b1);
      wchk(16'h4810, 8'h11, 1'b1);
      rchk(16'h4810, 32'h02);
      wchk(16'h4814, 8'hff, 1'b0);
      wchk(16'h4814, 8'h00, 1'b1);
      rchk(16'h4814, 32'hff);
      chk({35'h0, ser, par}, {35'h0, 5'h02, 8'hff});
      wchk(16'h4818, 8'h04, 1'b0);
      wchk(16'h4818, 8'h05, 1'b1);
      wchk(16'h4818, 8'h00, 1'b1);
      rchk(16'h4818, 32'h04);
      wchk(16'h4818, 8'h01, 1'b0);
      rchk(16'h4a00, 32'hb77e);
      chk({29'h0, bad, nsens}, {29'h0, 16'hb77e, 3'h1});
      rchk(16'h4900, 32'h0);
      chk({47'h0, er}, 48'h1);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rst_chk;
      close_out;
   end
endmodule // testbench
